/* rtl/phy_diag_pkg.sv */
package phy_diag_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register indices; byte address is four times the index.
    localparam logic [9:0] IDX_CABLE = 10'h124;
    localparam logic [9:0] IDX_LINK = 10'h126;
    localparam logic [9:0] IDX_SYMERR = 10'h12A;
    localparam logic [9:0] IDX_IRQ = 10'h136;
    localparam logic [9:0] IDX_PHYCTL = 10'h13E;
    localparam logic [9:0] IDX_EVCLR = 10'h140;

    // Field positions.
    localparam int CT_EN_BIT = 15;
    localparam int CT_PAIR_LO = 12;
    localparam int CT_STAT_LO = 8;
    localparam int LINK1000_BIT = 1;
    localparam int LINK100_BIT = 0;
    localparam int IRQ_EN_LO = 8;
    localparam int JAB_EN_BIT = 9;

    // Reset values, the reserved PHYCTL bits and the failed status code.
    localparam logic JAB_EN_RST = 1'h1;
    localparam logic [15:0] PHYCTL_RSVD = 16'h0100;
    localparam logic [1:0] PAIR_RST = 2'h0;
    localparam logic [1:0] CS_FAILED = 2'h3;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Longest wait for the analog measurement before the test fails.
    localparam int CLK_HZ = 40_000_000;
    localparam int CT_TIMEOUT_US = 100;
    localparam int CT_TIMEOUT_CYC = CLK_HZ / 1_000_000 * CT_TIMEOUT_US;
    localparam int CT_TMR_W = 12;

    typedef struct packed {
        logic jabber;
        logic rx_err;
        logic page_rx;
        logic pd_fault;
        logic lp_ack;
        logic link_down;
        logic remote_fault;
        logic link_up;
    } phy_evt_t;

    // Raw event sources from the PHY core, without link transitions.
    typedef struct packed {
        logic jabber;
        logic rx_err;
        logic page_rx;
        logic pd_fault;
        logic lp_ack;
        logic remote_fault;
    } phy_src_t;

    typedef struct packed {
        logic [1:0] status;
        logic [7:0] distance;
    } cable_result_t;

    typedef enum {CT_IDLE, CT_RUN} ct_state_t;

    typedef enum {
        SEL_NONE, SEL_CABLE, SEL_LINK, SEL_SYMERR, SEL_IRQ, SEL_PHYCTL,
        SEL_EVCLR
    } reg_sel_t;

endpackage

/* rtl/phy_cable_diag_status_irq.sv */
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module phy_cable_diag_status_irq (
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus.
    input wire logic [phy_diag_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [phy_diag_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [phy_diag_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [phy_diag_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Asynchronous line-side pins.
    input wire logic link_1000_up,
    input wire logic link_100_up,
    input wire phy_diag_pkg::phy_src_t phy_event_src,
    input wire logic receive_symbol_error,
    // Cable tester handshake.
    input wire logic cable_meas_done,
    input wire phy_diag_pkg::cable_result_t cable_meas_result,
    // Outputs, all from flops.
    output logic cable_test_run,
    output logic [1:0] cable_test_pair,
    output logic irq
);

    // Bits carried by the synchroniser.
    localparam int SYNC_W = 20;

    // Decode used by both the read and the write path.
    function automatic phy_diag_pkg::reg_sel_t decode(
        input logic [phy_diag_pkg::ADDR_W-1:0] addr
    );
        phy_diag_pkg::reg_sel_t sel;
        sel = phy_diag_pkg::SEL_NONE;
        // Misaligned addresses map to nothing.
        if (addr[1:0] == 2'h0) begin
            unique case (addr[11:2])
                phy_diag_pkg::IDX_CABLE: sel = phy_diag_pkg::SEL_CABLE;
                phy_diag_pkg::IDX_LINK: sel = phy_diag_pkg::SEL_LINK;
                phy_diag_pkg::IDX_SYMERR: sel = phy_diag_pkg::SEL_SYMERR;
                phy_diag_pkg::IDX_IRQ: sel = phy_diag_pkg::SEL_IRQ;
                phy_diag_pkg::IDX_PHYCTL: sel = phy_diag_pkg::SEL_PHYCTL;
                phy_diag_pkg::IDX_EVCLR: sel = phy_diag_pkg::SEL_EVCLR;
                default: sel = phy_diag_pkg::SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    // Synchroniser stages and pin views.
    logic [SYNC_W-1:0] async_in;
    logic [SYNC_W-1:0] meta_r;
    logic [SYNC_W-1:0] sync_r;
    logic [SYNC_W-1:0] prev_r;
    logic l1000_s;
    logic l100_s;
    logic link_any_s;
    logic link_any_p;
    phy_diag_pkg::phy_src_t src_s;
    phy_diag_pkg::phy_src_t src_p;
    logic symerr_rise;
    logic done_rise;
    phy_diag_pkg::cable_result_t meas_s;

    // Bus channel state.
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic aw_got_r;
    logic w_got_r;
    logic [phy_diag_pkg::ADDR_W-1:0] awaddr_r;
    logic [15:0] wdata_r;
    logic [1:0] wstrb_r;
    logic arready_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [phy_diag_pkg::DATA_W-1:0] rdata_r;

    // Decoded accesses.
    logic wr_do;
    phy_diag_pkg::reg_sel_t wr_sel;
    phy_diag_pkg::reg_sel_t rd_sel;
    logic rd_do;
    logic [15:0] rd_val;

    // Register contents.
    phy_diag_pkg::ct_state_t ct_state_r;
    logic ct_run_r;
    logic [1:0] pair_r;
    phy_diag_pkg::cable_result_t result_r;
    logic [phy_diag_pkg::CT_TMR_W-1:0] ct_tmr_r;
    logic [15:0] symerr_cnt_r;
    phy_diag_pkg::phy_evt_t evt_en_r;
    phy_diag_pkg::phy_evt_t evt_stat_r;
    phy_diag_pkg::phy_evt_t evt_set;
    phy_diag_pkg::phy_evt_t evt_clr;
    logic jab_en_r;
    logic irq_r;

    // Every pin input is asynchronous, so each bit gets two flops first.
    assign async_in = {link_1000_up, link_100_up, phy_event_src,
                       receive_symbol_error, cable_meas_done,
                       cable_meas_result};

    // The third stage only feeds edge detection.
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    meta_r[gi] <= 1'b0;
                    sync_r[gi] <= 1'b0;
                    prev_r[gi] <= 1'b0;
                end else begin
                    meta_r[gi] <= async_in[gi];
                    sync_r[gi] <= meta_r[gi];
                    prev_r[gi] <= sync_r[gi];
                end
            end
        end
    endgenerate

    // Edge detection only ever looks at the second and third stages.
    assign {l1000_s, l100_s, src_s, symerr_rise, done_rise, meas_s} =
        sync_r;
    // Previous levels for edge detection.
    assign src_p = prev_r[17:12];
    assign link_any_s = l1000_s | l100_s;
    assign link_any_p = prev_r[19] | prev_r[18];

    // Rising source edges (jabber only while enabled) and link changes become one-cycle events.
    always_comb begin
        evt_set.jabber = src_s.jabber & ~src_p.jabber & jab_en_r;
        evt_set.rx_err = src_s.rx_err & ~src_p.rx_err;
        evt_set.page_rx = src_s.page_rx & ~src_p.page_rx;
        evt_set.pd_fault = src_s.pd_fault & ~src_p.pd_fault;
        evt_set.lp_ack = src_s.lp_ack & ~src_p.lp_ack;
        // Link events follow either speed.
        evt_set.link_down = ~link_any_s & link_any_p;
        evt_set.remote_fault = src_s.remote_fault & ~src_p.remote_fault;
        evt_set.link_up = link_any_s & ~link_any_p;
    end

    // Write address and data may arrive in either order.
    assign wr_do = aw_got_r & w_got_r & ~bvalid_r;
    assign wr_sel = decode(awaddr_r);

    // Write channel.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= phy_diag_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && awready_r) begin
                awaddr_r <= s_axi_awaddr;
                aw_got_r <= 1'b1;
                awready_r <= 1'b0;
            end
            if (s_axi_wvalid && wready_r) begin
                wdata_r <= s_axi_wdata[15:0];
                wstrb_r <= s_axi_wstrb[1:0];
                w_got_r <= 1'b1;
                wready_r <= 1'b0;
            end
            // Commit and answer in one edge.
            if (wr_do) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= (wr_sel == phy_diag_pkg::SEL_NONE) ?
                    phy_diag_pkg::RESP_SLVERR : phy_diag_pkg::RESP_OKAY;
            end
            // Ready returns once the answer is taken.
            if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // Reads are sampled at the address handshake, so a clear-on-read
    // lands on the same edge and an event on that edge survives it.
    assign rd_do = s_axi_arvalid & arready_r;
    assign rd_sel = decode(s_axi_araddr);

    // Read mux; reserved bits read zero, except PHYCTL bit 8, which reads one.
    always_comb begin
        rd_val = '0;
        unique case (rd_sel)
            phy_diag_pkg::SEL_CABLE: begin
                rd_val[phy_diag_pkg::CT_EN_BIT] = ct_run_r;
                rd_val[phy_diag_pkg::CT_PAIR_LO +: 2] = pair_r;
                rd_val[phy_diag_pkg::CT_STAT_LO +: 2] = result_r.status;
                rd_val[7:0] = result_r.distance;
            end
            phy_diag_pkg::SEL_LINK: begin
                rd_val[phy_diag_pkg::LINK1000_BIT] = l1000_s;
                rd_val[phy_diag_pkg::LINK100_BIT] = l100_s;
            end
            phy_diag_pkg::SEL_SYMERR: rd_val = symerr_cnt_r;
            phy_diag_pkg::SEL_IRQ: rd_val = {evt_en_r, evt_stat_r};
            phy_diag_pkg::SEL_PHYCTL: begin
                rd_val = phy_diag_pkg::PHYCTL_RSVD;
                rd_val[phy_diag_pkg::JAB_EN_BIT] = jab_en_r;
            end
            phy_diag_pkg::SEL_EVCLR: rd_val = '0;
            phy_diag_pkg::SEL_NONE: rd_val = '0;
        endcase
    end

    // Read channel.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= phy_diag_pkg::RESP_OKAY;
            rdata_r <= '0;
        end else begin
            if (rd_do) begin
                arready_r <= 1'b0;
                rvalid_r <= 1'b1;
                rdata_r <= {16'h0000, rd_val};
                rresp_r <= (rd_sel == phy_diag_pkg::SEL_NONE) ?
                    phy_diag_pkg::RESP_SLVERR : phy_diag_pkg::RESP_OKAY;
            end
            // Rdata holds until rready is seen.
            if (rvalid_r && s_axi_rready) begin
                rvalid_r <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    // Cable test sequencer; a software write outranks a finishing test.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ct_state_r <= phy_diag_pkg::CT_IDLE;
            ct_run_r <= 1'b0;
            pair_r <= phy_diag_pkg::PAIR_RST;
            result_r <= '0;
            ct_tmr_r <= '0;
        end else if (wr_do && wr_sel == phy_diag_pkg::SEL_CABLE &&
                     wstrb_r[1]) begin
            pair_r <= wdata_r[phy_diag_pkg::CT_PAIR_LO +: 2];
            ct_tmr_r <= '0;
            if (wdata_r[phy_diag_pkg::CT_EN_BIT]) begin
                ct_state_r <= phy_diag_pkg::CT_RUN;
                ct_run_r <= 1'b1;
            end else begin
                ct_state_r <= phy_diag_pkg::CT_IDLE;
                ct_run_r <= 1'b0;
            end
        end else begin
            // The timer runs only while testing.
            unique case (ct_state_r)
                // Idle holds the timer cleared.
                phy_diag_pkg::CT_IDLE: ct_tmr_r <= '0;
                phy_diag_pkg::CT_RUN: begin
                    ct_tmr_r <= ct_tmr_r + 1'b1;
                    // Result settled before done rose.
                    if (done_rise && !prev_r[10]) begin
                        result_r <= meas_s;
                        ct_state_r <= phy_diag_pkg::CT_IDLE;
                        ct_run_r <= 1'b0;
                    end else if (ct_tmr_r == phy_diag_pkg::CT_TMR_W'(
                                 phy_diag_pkg::CT_TIMEOUT_CYC - 1)) begin
                        // A missing answer must not leave bit 15 stuck.
                        result_r.status <= phy_diag_pkg::CS_FAILED;
                        ct_state_r <= phy_diag_pkg::CT_IDLE;
                        ct_run_r <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Symbol-error frame counter saturates rather than wrapping to zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            symerr_cnt_r <= 16'h0000;
        end else begin
            // An event on the read edge counts as one.
            if (rd_do && rd_sel == phy_diag_pkg::SEL_SYMERR) begin
                symerr_cnt_r <= {15'h0000, symerr_rise & ~prev_r[11]};
            end else if (symerr_rise && !prev_r[11] &&
                         symerr_cnt_r != 16'hFFFF) begin
                symerr_cnt_r <= symerr_cnt_r + 16'h0001;
            end
        end
    end

    // Status clears on read or by write-one; a new event wins the clear.
    always_comb begin
        evt_clr = '0;
        if (rd_do && rd_sel == phy_diag_pkg::SEL_IRQ) begin
            evt_clr = '1;
        end
        // Only the status byte lane clears.
        if (wr_do && wr_sel == phy_diag_pkg::SEL_EVCLR && wstrb_r[0]) begin
            evt_clr = evt_clr | wdata_r[7:0];
        end
    end

    // Sticky status bits.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_stat_r <= '0;
        end else begin
            evt_stat_r <= (evt_stat_r & ~evt_clr) | evt_set;
        end
    end

    // Enables and the jabber gate; reserved bits are never stored.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_en_r <= '0;
            jab_en_r <= phy_diag_pkg::JAB_EN_RST;
        end else if (wr_do && wstrb_r[1]) begin
            // Status bits here are read-only.
            if (wr_sel == phy_diag_pkg::SEL_IRQ) begin
                evt_en_r <= wdata_r[phy_diag_pkg::IRQ_EN_LO +: 8];
            end
            if (wr_sel == phy_diag_pkg::SEL_PHYCTL) begin
                jab_en_r <= wdata_r[phy_diag_pkg::JAB_EN_BIT];
            end
        end
    end

    // Registered request lags the status by one cycle to stay glitch-free.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(evt_stat_r & evt_en_r);
        end
    end

    // Output ports.
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign cable_test_run = ct_run_r;
    assign cable_test_pair = pair_r;
    assign irq = irq_r;

endmodule
`default_nettype wire

/* testbench/phy_cable_diag_status_irq_chk.sv */
`timescale 1ns/10ps
`default_nettype none
// Watches the register port, the cable tester pins and the link pins.
module phy_diag_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic link_1000_up,
    input wire logic link_100_up,
    input wire logic cable_meas_done,
    input wire logic cable_test_run,
    input wire logic [1:0] cable_test_pair,
    input wire logic irq
);
    logic wr_hs;
    logic wr_ct;
    logic rd_lk;
    // Only writes whose two halves meet at one edge are judged here.
    assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready;
    assign wr_ct = wr_hs && s_axi_awaddr == 12'h490 && s_axi_wstrb[1];
    assign rd_lk = s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h498;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_rst;
        $rose(aresetn) |-> !irq && !cable_test_run && !s_axi_bvalid;
    endproperty
    a_rst: assert property (p_rst) else $error("busy after reset");
    property p_start;
        wr_ct && s_axi_wdata[15] |=> ##1 cable_test_run
            && cable_test_pair == $past(s_axi_wdata[13:12], 2);
    endproperty
    a_start: assert property (p_start) else $error("test not started");
    property p_rise;
        $rose(cable_test_run) |-> $rose(s_axi_bvalid);
    endproperty
    a_rise: assert property (p_rise) else $error("test ran unasked");
    property p_done;
        cable_test_run && $rose(cable_meas_done) |-> ##[1:5] !cable_test_run;
    endproperty
    a_done: assert property (p_done) else $error("test never ended");
    property p_abort;
        wr_ct && !s_axi_wdata[15] |=> ##1 !cable_test_run;
    endproperty
    a_abort: assert property (p_abort) else $error("abort ignored");
    property p_irq_fall;
        $fell(irq) |-> $past(s_axi_rvalid) || $past(s_axi_bvalid);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq lost");
    property p_gig;
        link_1000_up [*4] ##0 rd_lk |=> s_axi_rdata[1];
    endproperty
    a_gig: assert property (p_gig) else $error("gigabit link bit");
    property p_fast;
        !link_100_up [*4] ##0 rd_lk |=> !s_axi_rdata[0];
    endproperty
    a_fast: assert property (p_fast) else $error("fast link bit");
    property p_upper;
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper data set");
    property p_miss;
        wr_hs && s_axi_awaddr == 12'h000 |=> ##1
            s_axi_bvalid && s_axi_bresp == phy_diag_pkg::RESP_SLVERR;
    endproperty
    a_miss: assert property (p_miss) else $error("unmapped write ok");
    c_run: cover property ($rose(cable_test_run));
    c_irq: cover property ($rose(irq));
    c_gig: cover property (rd_lk && link_1000_up);
endmodule
bind phy_cable_diag_status_irq phy_diag_chk i_phy_diag_chk (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .link_1000_up, .link_100_up, .cable_meas_done, .cable_test_run,
    .cable_test_pair, .irq);
`default_nettype wire

/* testbench/cable_tester_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Analog tester stand-in: answers a running test after delay cycles, or
// never while mute, so the timeout path can be reached.
module cable_tester_model (
    input wire logic aclk,
    input wire logic cable_test_run,
    input wire logic [7:0] delay,
    input wire logic mute,
    input wire phy_diag_pkg::cable_result_t answer,
    output logic cable_meas_done,
    output phy_diag_pkg::cable_result_t cable_meas_result
);
    logic [7:0] cnt_r;
    // Outside the answer window the result toggles, so a late sample fails.
    always_ff @(posedge aclk) begin
        if (!cable_test_run || mute || cnt_r < delay)
            cable_meas_result <= (cable_meas_result == ~answer) ?
                answer ^ 10'h2AA : ~answer;
        else
            cable_meas_result <= answer;
    end
    // Done rises four cycles after the result settles and ends the test.
    always_ff @(posedge aclk) begin
        if (!cable_test_run || mute)
            cnt_r <= 8'h00;
        else if (cnt_r < delay + 8'h04)
            cnt_r <= cnt_r + 8'h01;
        cable_meas_done <= cable_test_run && !mute &&
            cnt_r >= delay + 8'h04;
    end
endmodule
`default_nettype wire

/* testbench/tb_phy_cable_diag_status_irq.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_phy_cable_diag_status_irq;
    localparam logic [11:0] A_CT = 12'h490;
    localparam logic [11:0] A_LK = 12'h498;
    localparam logic [11:0] A_SE = 12'h4A8;
    localparam logic [11:0] A_IR = 12'h4D8;
    localparam logic [11:0] A_PC = 12'h4F8;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] strb = 4'h3;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic l1000 = 1'b0;
    logic l100 = 1'b0;
    logic sym_err = 1'b0;
    logic mute = 1'b0;
    logic [7:0] dly = 8'h10;
    phy_diag_pkg::phy_src_t src = '0;
    phy_diag_pkg::cable_result_t ans = '0;
    phy_diag_pkg::cable_result_t res;
    logic awready, wready, bvalid, arready, rvalid, run, irq, done;
    logic [1:0] bresp, rresp, pair;
    logic [31:0] rdata;
    int miscompares = 0;
    int n_tests = 0;
    // The clock runs at 40 MHz.
    always #12.5 aclk = ~aclk;
    phy_cable_diag_status_irq i_phy_cable_diag_status_irq (.aclk(aclk),
        .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .link_1000_up(l1000), .link_100_up(l100), .phy_event_src(src),
        .receive_symbol_error(sym_err), .cable_meas_done(done),
        .cable_meas_result(res), .cable_test_run(run),
        .cable_test_pair(pair), .irq(irq));
    cable_tester_model i_cable_tester_model (.aclk(aclk),
        .cable_test_run(run), .delay(dly), .mute(mute), .answer(ans),
        .cable_meas_done(done), .cable_meas_result(res));
    task automatic test_done;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Bready and rready stay high, so the answer is taken when it shows.
    task automatic bus(input logic w, input logic [11:0] a,
            input logic [15:0] d, output logic [17:0] q);
        int n;
        n = 0;
        if (w) begin
            awaddr <= a;
            wdata <= {16'h0000, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
        end else begin
            araddr <= a;
            arvalid <= 1'b1;
        end
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (arvalid && arready)
                arvalid <= 1'b0;
        end while (!(w ? bvalid : rvalid) && n < 40);
        q = w ? {bresp, 16'h0000} : {rresp, rdata[15:0]};
        if (n >= 40) begin
            miscompares++;
            test_done();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic [17:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [15:0] e);
        logic [17:0] q;
        bus(1'b0, a, 16'h0000, q);
        chk(q[15:0], e);
    endtask
    // Polls the run bit; a hung test ends the run rather than the wait.
    task automatic poll_idle(output logic [17:0] q);
        int n;
        n = 0;
        do begin
            bus(1'b0, A_CT, 16'h0000, q);
            n++;
        end while (q[15] && n < 3000);
        if (n >= 3000) begin
            miscompares++;
            test_done();
        end
    endtask
    task automatic pulse(input int i, input logic e);
        src <= phy_diag_pkg::phy_src_t'(6'(1 << i));
        repeat (4) @(posedge aclk);
        src <= '0;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        chk(16'(irq), 16'(e));
        @(posedge aclk);
    endtask
    function automatic logic [15:0] ct_val(input logic r, input logic [1:0] p,
            input logic [9:0] v);
        return {r, 1'b0, p, 2'b00, v};
    endfunction
    function automatic logic [7:0] ev_bit(input int i);
        return (i == 0) ? 8'h02 : 8'h08 << (i - 1);
    endfunction
    initial begin
        logic [17:0] q;
        logic [9:0] last;
        logic [7:0] m;
        int k;
        void'($urandom(32'h25C5));
        last = 10'h000;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdc(A_CT, 16'h0000);
        rdc(A_IR, 16'h0000);
        rdc(A_SE, 16'h0000);
        rdc(A_LK, 16'h0000);
        rdc(A_PC, 16'h0200 | phy_diag_pkg::PHYCTL_RSVD);
        bus(1'b1, 12'h000, 16'hFFFF, q);
        chk(16'(q[17:16]), 16'(phy_diag_pkg::RESP_SLVERR));
        bus(1'b0, 12'h492, 16'h0000, q);
        chk(16'(q[17:16]), 16'(phy_diag_pkg::RESP_SLVERR));
        $display("end of reset test");
        // Every pair and every outcome code, each with a random delay.
        for (k = 0; k < 4; k++) begin
            ans <= {2'(3 - k), 8'($urandom)};
            dly <= 8'(8 + $urandom % 60);
            wr(A_CT, ct_val(1'b1, 2'(k), 10'h000));
            rdc(A_CT, ct_val(1'b1, 2'(k), last));
            poll_idle(q);
            last = ans;
            chk(q[15:0], ct_val(1'b0, 2'(k), last));
        end
        strb <= 4'h1;
        wr(A_CT, 16'h8000);
        strb <= 4'h3;
        rdc(A_CT, ct_val(1'b0, 2'h3, last));
        mute <= 1'b1;
        wr(A_CT, 16'h9000);
        wr(A_CT, 16'h1000);
        rdc(A_CT, ct_val(1'b0, 2'h1, last));
        wr(A_CT, 16'hA000);
        poll_idle(q);
        chk(q[15:0], ct_val(1'b0, 2'h2, {2'h3, last[7:0]}));
        mute <= 1'b0;
        $display("end of cable test");
        // Each source alone, enabled for odd k and masked for even k; other enables random.
        for (k = 0; k < 6; k++) begin
            m = 8'($urandom);
            m = k[0] ? m | ev_bit(k) : m & ~ev_bit(k);
            wr(A_IR, {m, 8'h00});
            pulse(k, |(m & ev_bit(k)));
            rdc(A_IR, {m, ev_bit(k)});
            rdc(A_IR, {m, 8'h00});
        end
        wr(A_PC, 16'h0000);
        rdc(A_PC, phy_diag_pkg::PHYCTL_RSVD);
        pulse(5, 1'b0);
        rdc(A_IR, {m, 8'h00});
        wr(A_PC, 16'h0200);
        $display("end of event test");
        // Link levels one by one, then the up event cleared by write-one and the down event checked.
        wr(A_IR, 16'hFF00);
        for (k = 0; k < 4; k++) begin
            l1000 <= k[1];
            l100 <= k[0];
            repeat (6) @(posedge aclk);
            rdc(A_LK, 16'(k));
        end
        wr(12'h500, 16'h0001);
        @(negedge aclk);
        chk(16'(irq), 16'h0000);
        @(posedge aclk);
        l1000 <= 1'b0;
        l100 <= 1'b0;
        repeat (6) @(posedge aclk);
        chk(16'(irq), 16'h0001);
        rdc(A_IR, 16'hFF04);
        @(negedge aclk);
        chk(16'(irq), 16'h0000);
        @(posedge aclk);
        $display("end of link test");
        // Frames with symbol errors are counted and cleared by a read.
        k = 1 + $urandom % 12;
        repeat (k) begin
            sym_err <= 1'b1;
            repeat (3) @(posedge aclk);
            sym_err <= 1'b0;
            repeat (3) @(posedge aclk);
        end
        rdc(A_SE, 16'(k));
        rdc(A_SE, 16'h0000);
        $display("end of counter test");
        test_done();
    end
endmodule
`default_nettype wire
